// ==== hw/lics_pkg.sv ====
package lics_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ             = 40_000_000;
  localparam int unsigned FLASH_HZ           = 2;
  // Half period of the fault flash, in clock cycles
  localparam int unsigned FLASH_HALF_CYCLES  = CLK_HZ / (FLASH_HZ * 2);
  localparam int unsigned DET_INTERVAL_MS    = 250;
  localparam int unsigned DET_CYCLES         = (CLK_HZ / 1000) * DET_INTERVAL_MS;
  // Fast-charge limit as a multiple of the precharge limit
  localparam int unsigned FAST_TO_PRE_RATIO  = 10;
  // Internal default precharge limit in timer ticks
  localparam int unsigned DEFAULT_PRE_TICKS  = 1800;
  localparam int unsigned TICK_W             = 32;
  localparam int unsigned RATE_W             = 8;
  localparam logic [7:0]  RATE_FULL          = 8'h00_FF;

  // ****************************************************************
  // Timer pin strap decode
  // ****************************************************************
  typedef enum logic [1:0]
  {
    LICS_TMR_RES     = 2'h0_0,
    LICS_TMR_OPEN    = 2'h0_1,
    LICS_TMR_GROUND  = 2'h0_2
  } lics_tmr_mode_t;

  // ****************************************************************
  // Sequencer states, one-hot
  // ****************************************************************
  typedef enum logic [8:0]
  {
    LICS_IDLE     = 9'h0_001,
    LICS_SHORT    = 9'h0_002,
    LICS_PRE      = 9'h0_004,
    LICS_FAST     = 9'h0_008,
    LICS_CV       = 9'h0_010,
    LICS_DONE     = 9'h0_020,
    LICS_DET_DRAW = 9'h0_040,
    LICS_DET_PRE  = 9'h0_080,
    LICS_FAULT    = 9'h0_100
  } lics_state_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed
  {
    logic bat_above_short;
    logic bat_above_lowv;
    logic bat_above_rch;
    logic bat_at_reg;
    logic cur_at_term;
    logic thermal_reg;
    logic dppm_active;
    logic vin_dpm_active;
    logic charge_current_set_above_ilim;
    logic thermal_shutdown;
    logic temp_out_of_range;
  } lics_sense_t;

  typedef struct packed
  {
    logic short_test_current;
    logic precharge_current;
    logic fast_charge_current;
    logic cv_regulate;
    logic detect_draw;
  } lics_drive_t;

endpackage

// ==== hw/lics_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser for a bundle of asynchronous levels
module lics_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic [W-1:0]      sync_out
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ==== hw/lics_timer.sv ====
`timescale 1ns/1ps
// Safety timer: fractional-rate accumulator producing ticks, then tick counter
module lics_timer #(
  parameter int unsigned TW = lics_pkg::TICK_W,
  parameter int unsigned RW = lics_pkg::RATE_W
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Control
  input  wire logic          clear,
  input  wire logic          run,
  input  wire logic [RW-1:0] rate,
  input  wire logic [TW-1:0] limit,
  input  wire logic [31:0]   tick_cycles,
  // Status
  output logic               expired
);

  localparam int unsigned AW = $bits(tick_cycles) + RW;

  logic [AW-1:0] acc_reg;
  logic [TW-1:0] cnt_reg;
  logic [AW-1:0] acc_sum;
  logic [AW-1:0] tick_span;
  logic          tick;

  // A reduced rate stretches each tick in proportion
  assign tick_span = AW'(tick_cycles) * AW'(lics_pkg::RATE_FULL);
  assign acc_sum   = acc_reg + AW'(rate);
  assign tick      = acc_sum >= tick_span;

  // Accumulator: frozen value kept while run and clear are both low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      acc_reg <= '0;
    else if (clear)
      acc_reg <= '0;
    else if (run)
    begin
      if (tick)
        acc_reg <= acc_sum - tick_span;
      else
        acc_reg <= acc_sum;
    end
  end

  // Tick counter and expiry
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
      expired <= 1'b0;
    end
    else if (clear)
    begin
      cnt_reg <= '0;
      expired <= 1'b0;
    end
    else if (run && tick)
    begin
      cnt_reg <= cnt_reg + 1'b1;
      if (cnt_reg + 1'b1 >= limit)
        expired <= 1'b1;
    end
  end

endmodule

// ==== hw/lics_sequencer.sv ====
`timescale 1ns/1ps
module lics_sequencer #(
  parameter int unsigned DET_CYC   = lics_pkg::DET_CYCLES,
  parameter int unsigned FLASH_CYC = lics_pkg::FLASH_HALF_CYCLES,
  parameter int unsigned TICK_CYC  = lics_pkg::CLK_HZ,
  parameter int unsigned PRE_DEF   = lics_pkg::DEFAULT_PRE_TICKS
) (
  // Clock and power-on reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Host and strap pins
  input  wire logic                      charge_enable_n,
  input  wire logic                      termination_disable,
  input  wire logic                      battery_disconnect,
  input  wire logic                      input_power_ok,
  input  wire logic                      usb_suspend,
  input  wire logic                      overvoltage,
  input  wire lics_pkg::lics_tmr_mode_t  timer_program_pin,
  input  wire logic [lics_pkg::TICK_W-1:0] timer_pre_ticks,
  input  wire logic [lics_pkg::RATE_W-1:0] charge_rate,
  // Comparator flags
  input  wire lics_pkg::lics_sense_t     sense,
  // Analog loop controls
  output lics_pkg::lics_drive_t          drive,
  output logic                           battery_switch,
  // Open-drain status
  output logic                           charge_status_n_out,
  output logic                           charge_status_n_oe,
  // Observation
  output lics_pkg::lics_state_t          state_out,
  output logic                           timer_fault
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  localparam int unsigned NSYNC = $bits(lics_pkg::lics_sense_t) + 7;

  lics_pkg::lics_sense_t s;
  logic en_n_s;
  logic td_s;
  logic disc_s;
  logic pwr_s;
  logic susp_s;
  logic ovp_s;
  logic [1:0] tmr_s;

  lics_sync #(
    .W (NSYNC + 1)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({sense, charge_enable_n, termination_disable, battery_disconnect,
                input_power_ok, usb_suspend, overvoltage, timer_program_pin}),
    .sync_out ({s, en_n_s, td_s, disc_s, pwr_s, susp_s, ovp_s, tmr_s})
  );

  // ****************************************************************
  // Restart events
  // ****************************************************************
  logic en_n_d_reg;
  logic pwr_d_reg;
  logic susp_d_reg;
  logic ovp_d_reg;
  logic restart;
  logic active;

  // Edge history; reset matches the cleared synchroniser, so no false edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      en_n_d_reg <= 1'b0;
      pwr_d_reg  <= 1'b0;
      susp_d_reg <= 1'b0;
      ovp_d_reg  <= 1'b0;
    end
    else
    begin
      en_n_d_reg <= en_n_s;
      pwr_d_reg  <= pwr_s;
      susp_d_reg <= susp_s;
      ovp_d_reg  <= ovp_s;
    end
  end

  // Any toggle of enable, power or suspend, or an overvoltage exit, restarts the cycle
  assign restart = (en_n_d_reg != en_n_s) || (pwr_d_reg != pwr_s) ||
                   (susp_d_reg != susp_s) || (ovp_d_reg && !ovp_s);
  assign active  = !en_n_s && pwr_s && !susp_s && !ovp_s;

  // ****************************************************************
  // Charge state machine
  // ****************************************************************
  lics_pkg::lics_state_t state_reg;
  lics_pkg::lics_state_t state_next;
  logic [31:0] det_cnt_reg;
  logic        det_done;
  logic        pre_exp;
  logic        fast_exp;
  logic        term_ok;
  logic        current_reduced;
  logic        first_cycle_reg;
  logic        td_released_reg;

  assign det_done = det_cnt_reg >= DET_CYC;
  // Loops that cut current make the taper look like termination
  assign current_reduced = s.thermal_reg || s.dppm_active || s.vin_dpm_active;
  assign term_ok = s.cur_at_term && !current_reduced;

  // Next-state decode
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      lics_pkg::LICS_IDLE:
        if (active)
          state_next = lics_pkg::LICS_SHORT;
      lics_pkg::LICS_SHORT:
        if (s.bat_above_short)
          state_next = lics_pkg::LICS_PRE;
      lics_pkg::LICS_PRE:
        if (pre_exp)
          state_next = lics_pkg::LICS_FAULT;
        else if (s.bat_above_lowv)
          state_next = lics_pkg::LICS_FAST;
      lics_pkg::LICS_FAST:
        if (fast_exp)
          state_next = lics_pkg::LICS_FAULT;
        else if (s.bat_at_reg)
          state_next = lics_pkg::LICS_CV;
      lics_pkg::LICS_CV:
        if (fast_exp)
          state_next = lics_pkg::LICS_FAULT;
        else if (term_ok && !td_s)
          state_next = lics_pkg::LICS_DONE;
      lics_pkg::LICS_DONE:
        if (!s.bat_above_rch && !td_s)
          state_next = lics_pkg::LICS_DET_DRAW;
      lics_pkg::LICS_DET_DRAW:
        if (!s.bat_above_lowv)
          state_next = lics_pkg::LICS_DET_PRE;
        else if (det_done)
          state_next = lics_pkg::LICS_SHORT;
      lics_pkg::LICS_DET_PRE:
        if (det_done)
          state_next = s.bat_above_rch ? lics_pkg::LICS_DET_DRAW
                                       : lics_pkg::LICS_SHORT;
      lics_pkg::LICS_FAULT:
        state_next = lics_pkg::LICS_FAULT;
      default:
        state_next = lics_pkg::LICS_IDLE;
    endcase
    if (!active || restart)
      state_next = lics_pkg::LICS_IDLE;
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_reg <= lics_pkg::LICS_IDLE;
    else
      state_reg <= state_next;
  end

  // Detection interval counter, restarted on each detection step
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      det_cnt_reg <= '0;
    else if (state_next != state_reg)
      det_cnt_reg <= '0;
    else if (!det_done)
      det_cnt_reg <= det_cnt_reg + 32'h0000_0001;
  end

  // First-cycle flag: set on power-up and on any enable, power or suspend toggle or overvoltage exit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      first_cycle_reg <= 1'b1;
    else if (restart)
      first_cycle_reg <= 1'b1;
    else if (state_reg == lics_pkg::LICS_DONE)
      first_cycle_reg <= 1'b0;
  end

  // Release latch for the no-termination mode; held until a toggle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      td_released_reg <= 1'b0;
    else if (restart)
      td_released_reg <= 1'b0;
    else if (td_s && state_reg == lics_pkg::LICS_CV && s.cur_at_term)
      td_released_reg <= 1'b1;
  end

  // ****************************************************************
  // Safety timers
  // ****************************************************************
  logic                        timers_on;
  logic                        frozen;
  logic [lics_pkg::TICK_W-1:0] pre_limit;
  logic [lics_pkg::TICK_W-1:0] fast_limit;
  logic [lics_pkg::RATE_W-1:0] fast_rate;

  assign timers_on = !td_s && (tmr_s != lics_pkg::LICS_TMR_GROUND);
  assign frozen    = s.thermal_shutdown || s.temp_out_of_range;
  assign pre_limit = (tmr_s == lics_pkg::LICS_TMR_OPEN) ?
                     lics_pkg::TICK_W'(PRE_DEF) : timer_pre_ticks;
  assign fast_limit = lics_pkg::TICK_W'(pre_limit * lics_pkg::FAST_TO_PRE_RATIO);
  // Rate falls with any current-limiting loop or input limit below set current
  assign fast_rate = (current_reduced || s.charge_current_set_above_ilim) ?
                     charge_rate : lics_pkg::RATE_FULL;

  lics_timer u_pre_timer (
    .clk         (clk),
    .rst         (rst),
    .clear       (state_reg != lics_pkg::LICS_PRE),
    .run         (timers_on && !frozen),
    .rate        (lics_pkg::RATE_FULL),
    .limit       (pre_limit),
    .tick_cycles (TICK_CYC),
    .expired     (pre_exp)
  );

  lics_timer u_fast_timer (
    .clk         (clk),
    .rst         (rst),
    .clear       (state_reg != lics_pkg::LICS_FAST && state_reg != lics_pkg::LICS_CV),
    .run         (timers_on && !frozen),
    .rate        (fast_rate),
    .limit       (fast_limit),
    .tick_cycles (TICK_CYC),
    .expired     (fast_exp)
  );

  // ****************************************************************
  // Fault flash
  // ****************************************************************
  logic [31:0] flash_cnt_reg;
  logic        flash_reg;

  // Half-period counter toggles the flash phase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flash_cnt_reg <= '0;
      flash_reg     <= 1'b0;
    end
    else if (state_reg != lics_pkg::LICS_FAULT)
    begin
      flash_cnt_reg <= '0;
      flash_reg     <= 1'b0;
    end
    else if (flash_cnt_reg >= FLASH_CYC - 1)
    begin
      flash_cnt_reg <= '0;
      flash_reg     <= !flash_reg;
    end
    else
      flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
  end

  // ****************************************************************
  // Outputs, all registered
  // ****************************************************************
  logic charging_now;
  assign charging_now = state_reg == lics_pkg::LICS_SHORT || state_reg == lics_pkg::LICS_PRE ||
                        state_reg == lics_pkg::LICS_FAST  || state_reg == lics_pkg::LICS_CV;

  // Analog loop enables; temperature fault suspends precharge, fast and CV current but keeps state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      drive <= '0;
    else
    begin
      drive.short_test_current  <= state_next == lics_pkg::LICS_SHORT;
      drive.precharge_current   <= !s.temp_out_of_range &&
                                   (state_next == lics_pkg::LICS_PRE ||
                                    state_next == lics_pkg::LICS_DET_PRE);
      drive.fast_charge_current <= !s.temp_out_of_range &&
                                   state_next == lics_pkg::LICS_FAST;
      drive.cv_regulate         <= !s.temp_out_of_range &&
                                   state_next == lics_pkg::LICS_CV;
      drive.detect_draw         <= state_next == lics_pkg::LICS_DET_DRAW;
    end
  end

  // Battery switch opens while disconnect is requested
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      battery_switch <= 1'b0;
    else
      battery_switch <= !disc_s;
  end

  // Open-drain status: enable high pulls the pin low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      charge_status_n_out <= 1'b0;
      charge_status_n_oe  <= 1'b0;
    end
    else
    begin
      charge_status_n_out <= 1'b0;
      if (disc_s)
        charge_status_n_oe <= 1'b1;
      else if (state_reg == lics_pkg::LICS_FAULT)
        charge_status_n_oe <= flash_reg;
      else
        charge_status_n_oe <= charging_now && first_cycle_reg && !td_released_reg;
    end
  end

  // Observation registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_out   <= lics_pkg::LICS_IDLE;
      timer_fault <= 1'b0;
    end
    else
    begin
      state_out   <= state_reg;
      timer_fault <= state_reg == lics_pkg::LICS_FAULT;
    end
  end

endmodule

// ==== bench/lics_sequencer_properties.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Port-level checks of the charge sequencer
// ****************************************************************
module lics_sequencer_properties #(
  parameter int unsigned FLASH_CYC = 4
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  // Pins
  input wire logic                  termination_disable,
  input wire logic                  battery_disconnect,
  // Outputs under check
  input wire logic                  battery_switch,
  input wire logic                  charge_status_n_oe,
  input wire lics_pkg::lics_state_t state_out,
  input wire logic                  timer_fault
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic [31:0] still_reg;

  // Cycles since the status pin last moved during a fault; a stuck flash grows it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      still_reg <= '0;
    else if (!timer_fault || battery_disconnect || $changed(charge_status_n_oe))
      still_reg <= '0;
    else
      still_reg <= still_reg + 1;
  end

  chk_switch_open: assert property (battery_disconnect[*4] |-> !battery_switch)
    else $error("battery switch closed while disconnect held");
  chk_switch_close: assert property ((!battery_disconnect)[*4] |-> battery_switch)
    else $error("battery switch open while disconnect low");
  chk_status_disc: assert property (battery_disconnect[*6] |-> charge_status_n_oe)
    else $error("status not pulled low during disconnect");
  chk_enter_short: assert property ($past(state_out) == lics_pkg::LICS_IDLE
      && state_out != lics_pkg::LICS_IDLE |-> state_out == lics_pkg::LICS_SHORT)
    else $error("idle left without short test");
  chk_fast_from_pre: assert property (state_out == lics_pkg::LICS_FAST
      && $past(state_out) != lics_pkg::LICS_FAST |-> $past(state_out) == lics_pkg::LICS_PRE)
    else $error("fast charge entered not from precharge");
  chk_cv_from_fast: assert property (state_out == lics_pkg::LICS_CV
      && $past(state_out) != lics_pkg::LICS_CV |-> $past(state_out) == lics_pkg::LICS_FAST)
    else $error("constant voltage entered not from fast charge");
  chk_done_from_cv: assert property (state_out == lics_pkg::LICS_DONE
      && $past(state_out) != lics_pkg::LICS_DONE |-> $past(state_out) == lics_pkg::LICS_CV)
    else $error("done entered not from constant voltage");
  chk_done_release: assert property ((state_out == lics_pkg::LICS_DONE
      && !battery_disconnect)[*6] |-> !charge_status_n_oe)
    else $error("status still low when done");
  chk_td_no_done: assert property (termination_disable[*6] ##0
      $past(state_out) == lics_pkg::LICS_CV |-> state_out != lics_pkg::LICS_DONE)
    else $error("terminated with termination disabled");
  chk_td_no_detect: assert property (termination_disable[*6] ##0
      $past(state_out) != lics_pkg::LICS_DET_DRAW |-> state_out != lics_pkg::LICS_DET_DRAW)
    else $error("detection run with termination disabled");
  chk_fault_exit: assert property ($past(state_out) == lics_pkg::LICS_FAULT
      && state_out != lics_pkg::LICS_FAULT |-> state_out == lics_pkg::LICS_IDLE)
    else $error("fault left other than to idle");
  chk_fault_flag: assert property ($rose(timer_fault) |-> ##[0:2]
      state_out == lics_pkg::LICS_FAULT)
    else $error("fault flag without fault state");
  chk_flash_period: assert property (still_reg <= FLASH_CYC + 1)
    else $error("status not flashing during fault");

  // Main scenarios reached
  cov_done: cover property (state_out == lics_pkg::LICS_DONE);
  cov_det_pre: cover property (state_out == lics_pkg::LICS_DET_PRE);
  cov_fault: cover property (timer_fault ##1 $changed(charge_status_n_oe));
endmodule

bind lics_sequencer lics_sequencer_properties #(.FLASH_CYC(FLASH_CYC)) chk_inst (
  .clk                 (clk),
  .rst                 (rst),
  .termination_disable (termination_disable),
  .battery_disconnect  (battery_disconnect),
  .battery_switch      (battery_switch),
  .charge_status_n_oe  (charge_status_n_oe),
  .state_out           (state_out),
  .timer_fault         (timer_fault)
);

// ==== bench/lics_battery_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Behavioural battery pack seen through the comparators
// ****************************************************************
module lics_battery_model (
  // Clock
  input  wire logic                  clk,
  // Bench controls
  input  wire logic                  present,
  input  wire logic                  slow,
  input  wire logic                  discharge,
  input  wire logic                  thermal,
  // Charger side
  input  wire lics_pkg::lics_drive_t drive,
  output lics_pkg::lics_sense_t      sense
);
  int   lvl    = 0;
  int   cv_cyc = 0;
  int   age    = 0;
  logic src;

  assign src = drive.short_test_current | drive.precharge_current | drive.fast_charge_current;

  // Level steps once a cycle; a slow pack only every 32 cycles to trip the timers.
  // An absent pack jumps with whatever the charger does to the empty terminal.
  always @(posedge clk)
  begin
    age <= age + 1;
    if (discharge && lvl > 0)
      lvl <= lvl - 1;
    else if (!present)
      lvl <= src ? 15 : (drive.detect_draw ? 0 : lvl);
    else if (src && lvl < 15 && (!slow || age % 32 == 0))
      lvl <= lvl + 1;
    cv_cyc <= drive.cv_regulate ? cv_cyc + 1 : 0;
  end

  // Comparator flags; taper current reaches the end level after some CV time
  assign sense = '{bat_above_short: (lvl > 2), bat_above_lowv: (lvl > 4),
                   bat_above_rch: (lvl > 12), bat_at_reg: (lvl >= 15),
                   cur_at_term: (cv_cyc > 8), thermal_reg: thermal, default: 1'b0};
endmodule

// ==== bench/lics_sequencer_bench.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench of the charge sequencer
// ****************************************************************
module lics_sequencer_bench;
  logic                     clk                 = 0;
  logic                     rst                 = 1;
  logic                     charge_enable_n     = 1;
  logic                     termination_disable = 0;
  logic                     battery_disconnect  = 0;
  logic                     input_power_ok      = 1;
  logic                     usb_suspend         = 0;
  logic                     overvoltage         = 0;
  lics_pkg::lics_tmr_mode_t timer_program_pin   = lics_pkg::LICS_TMR_OPEN;
  logic [31:0]              timer_pre_ticks     = 32'h0000_0003;
  logic [7:0]               charge_rate         = lics_pkg::RATE_FULL;
  logic                     present             = 1;
  logic                     slow                = 0;
  logic                     discharge           = 0;
  logic                     thermal             = 0;
  lics_pkg::lics_sense_t    sense;
  lics_pkg::lics_drive_t    drive;
  lics_pkg::lics_state_t    state_out;
  logic                     battery_switch;
  logic                     status_out;
  logic                     status_oe;
  logic                     timer_fault;
  int                       n_fail              = 0;
  int                       n_checks            = 0;

  always #12.5 clk = ~clk;

  // Short counts so detection, flash and timers fit a short run
  lics_sequencer #(.DET_CYC(20), .FLASH_CYC(4), .TICK_CYC(2), .PRE_DEF(5)) uut (
    .clk(clk), .rst(rst), .charge_enable_n(charge_enable_n),
    .termination_disable(termination_disable), .battery_disconnect(battery_disconnect),
    .input_power_ok(input_power_ok), .usb_suspend(usb_suspend), .overvoltage(overvoltage),
    .timer_program_pin(timer_program_pin), .timer_pre_ticks(timer_pre_ticks),
    .charge_rate(charge_rate), .sense(sense), .drive(drive), .battery_switch(battery_switch),
    .charge_status_n_out(status_out), .charge_status_n_oe(status_oe),
    .state_out(state_out), .timer_fault(timer_fault));

  lics_battery_model pack (.clk(clk), .present(present), .slow(slow),
    .discharge(discharge), .thermal(thermal), .drive(drive), .sense(sense));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Sampled on the falling edge, away from the outputs' update
  task automatic wait_state(input lics_pkg::lics_state_t s, input int lim);
    int i;
    i = 0;
    do
    begin
      @(negedge clk);
      i++;
    end
    while (state_out !== s && i < lim);
    check($sformatf("state %s", s.name()), 32'(s), 32'(state_out));
  endtask

  // Enable toggle restarts a cycle; pack first drained to empty
  task automatic restart();
    @(posedge clk) discharge <= 1;
    charge_enable_n <= 1;
    cyc(20);
    @(posedge clk) discharge <= 0;
    charge_enable_n <= 0;
  endtask

  task automatic t_first_cycle();
    wait_state(lics_pkg::LICS_SHORT, 20);
    check("short current", 1, drive.short_test_current);
    wait_state(lics_pkg::LICS_PRE, 20);
    wait_state(lics_pkg::LICS_FAST, 20);
    check("fast current", 1, drive.fast_charge_current);
    check("status first cycle", 1, status_oe);
    wait_state(lics_pkg::LICS_CV, 40);
    wait_state(lics_pkg::LICS_DONE, 40);
    cyc(3);
    check("status done", 0, status_oe);
  endtask

  task automatic t_recharge();
    @(posedge clk) discharge <= 1;
    wait_state(lics_pkg::LICS_DET_DRAW, 40);
    @(posedge clk) discharge <= 0;
    wait_state(lics_pkg::LICS_SHORT, 40);
    wait_state(lics_pkg::LICS_FAST, 40);
    check("status refresh", 0, status_oe);
    wait_state(lics_pkg::LICS_DONE, 80);
  endtask

  task automatic t_missing();
    @(posedge clk) discharge <= 1;
    present <= 0;
    wait_state(lics_pkg::LICS_DET_DRAW, 40);
    @(posedge clk) discharge <= 0;
    wait_state(lics_pkg::LICS_DET_PRE, 40);
    check("pre current", 1, drive.precharge_current);
    wait_state(lics_pkg::LICS_DET_DRAW, 40);
    @(posedge clk) present <= 1;
  endtask

  // Thermal loop active with halved rate: no termination until it lets go
  task automatic t_loops();
    @(posedge clk) thermal <= 1;
    charge_rate <= 8'h0080;
    restart();
    wait_state(lics_pkg::LICS_CV, 120);
    cyc(40);
    check("cv held under loop", 32'(lics_pkg::LICS_CV), 32'(state_out));
    @(posedge clk) thermal <= 0;
    charge_rate <= lics_pkg::RATE_FULL;
    wait_state(lics_pkg::LICS_DONE, 40);
  endtask

  task automatic t_term_disable();
    @(posedge clk) termination_disable <= 1;
    discharge <= 1;
    cyc(10);
    @(posedge clk) discharge <= 0;
    cyc(30);
    check("no detection", 32'(lics_pkg::LICS_DONE), 32'(state_out));
    restart();
    wait_state(lics_pkg::LICS_CV, 120);
    cyc(150);
    check("cv forever", 32'(lics_pkg::LICS_CV), 32'(state_out));
    check("status released", 0, status_oe);
    check("no timer fault", 0, timer_fault);
    @(posedge clk) termination_disable <= 0;
  endtask

  task automatic t_fault();
    int n;
    @(posedge clk) timer_program_pin <= lics_pkg::LICS_TMR_RES;
    slow <= 1;
    restart();
    wait_state(lics_pkg::LICS_FAULT, 300);
    check("fault flag", 1, timer_fault);
    n = 0;
    for (int i = 0; i < 40; i++)
    begin
      logic prev;
      prev = status_oe;
      @(negedge clk);
      if (status_oe !== prev)
        n++;
    end
    check("flash toggles", 1, 32'(n >= 9 && n <= 11));
    @(posedge clk) usb_suspend <= 1;
    cyc(6);
    @(posedge clk) usb_suspend <= 0;
    wait_state(lics_pkg::LICS_PRE, 300);
    check("fault cleared", 0, timer_fault);
  endtask

  task automatic t_ground();
    @(posedge clk) timer_program_pin <= lics_pkg::LICS_TMR_GROUND;
    restart();
    cyc(300);
    check("timers off", 0, timer_fault);
    @(posedge clk) slow <= 0;
    timer_program_pin <= lics_pkg::LICS_TMR_OPEN;
  endtask

  task automatic t_disconnect();
    @(posedge clk) battery_disconnect <= 1;
    cyc(8);
    check("switch open", 0, battery_switch);
    check("status low", 1, status_oe);
    check("status out", 0, status_out);
    @(posedge clk) battery_disconnect <= 0;
    cyc(8);
    check("switch closed", 1, battery_switch);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Whole run is about a thousand cycles; this cuts a hang at 20000 cycles
  initial
  begin
    #(25 * 20000);
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    cyc(10);
    @(posedge clk) rst <= 0;
    charge_enable_n <= 0;
    t_first_cycle();
    t_recharge();
    t_missing();
    t_loops();
    t_term_disable();
    t_fault();
    t_ground();
    t_disconnect();
    tally_and_finish();
  end
endmodule
